//--- lbc_ctrl.sv
// bus cycle controller and command strobe generator
`timescale 1ns/1ns
module lbc_ctrl
   import lbc_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic ADS_N,
   input wire logic [2:0] STATUS,
   input wire logic FAST_SELECT,
   input wire logic SLOW_SELECT,
   input wire logic ROM_SELECT,
   input wire logic HALF_WIDTH_BUS,
   input wire logic [3:0] BYTE_LANE_ENABLES_N,
   output logic MEM_READ_CMD_N,
   output logic IO_READ_CMD_N,
   output logic MEM_WRITE_CMD_N,
   output logic IO_WRITE_CMD_N,
   output logic IRQ_ACK_CMD_N,
   output logic CYCLE_DONE_N,
   output logic NEXT_ADDR_REQ_N,
   output logic ADDR_LATCH,
   output logic XCVR_DIRECTION,
   output logic XCVR_ENABLE_N,
   output logic ROM_OE_N,
   output logic [3:0] SRAM_WE_N,
   output logic SRAM_OE_N
);
   // ***********************************************
   // decode and timing selection
   // ***********************************************
   state_t state_q, state_d;
   logic [2:0] st_q;
   logic rom_q, pipe_q, float_slow_q;
   logic [3:0] cnt_q, be_n_q, cmd_hi_q, cmd_lo_q;
   logic mrd_q, iord_q, mwr_q, iowr_q, irq_ack_cmd_q;
   logic start;
   logic is_read, is_write, known;
   logic [3:0] ws_sel, len_sel, dly_sel, hi_sel, end_sel;
   logic cmd_on, last;

   // number of double clock periods for a given wait count
   function automatic logic [3:0] cyc_len(input logic [3:0] ws);
      cyc_len = 4'(BASE_DOUBLE_CLOCK + 4'(ws * DOUBLE_CLOCK_PER_T));
   endfunction

   assign start = !ADS_N && (state_q != S_CYCLE);
   // RQ6 status decode
   assign known = (STATUS == ST_IRQ_ACK_CMD) || (STATUS == ST_IORD) ||
      (STATUS == ST_IOWR) || (STATUS == ST_CODE) ||
      (STATUS == ST_DATA) || (STATUS == ST_MWR);
   assign is_write = STATUS[0];
   assign is_read = !STATUS[0];
   // RQ8 RQ9 RQ10 wait profile; RQ13 RQ14 pipelined flag from history
   assign ws_sel = SLOW_SELECT ?
      (pipe_q ? SLOW_WS_PIPE : SLOW_WS_UNPIPE) :
      is_write ? (pipe_q ? FAST_WR_WS_PIPE : FAST_WR_WS_UNPIPE) :
      (pipe_q ? FAST_RD_WS_PIPE : FAST_RD_WS_UNPIPE);
   assign len_sel = cyc_len(ws_sel);
   assign dly_sel = SLOW_SELECT ? SLOW_CMD_DLY : FAST_CMD_DLY;
   // command opens after the delay; the slower profile opens one later
   assign hi_sel = 4'(len_sel - dly_sel + 4'h1);
   // RQ11 slow rom reads hold the read strobe exactly four periods
   assign end_sel = (SLOW_SELECT && ROM_SELECT && is_read) ?
      4'(hi_sel - ROM_RD_WIDTH) : 4'h1;
   assign last = (state_q == S_CYCLE) && (cnt_q == 4'h1);
   // strobe stands while the count lies inside the latched window
   assign cmd_on = (state_q == S_CYCLE) && (cnt_q <= cmd_hi_q) &&
      (cnt_q > cmd_lo_q);

   // ***********************************************
   // state machine
   // ***********************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (start) state_d = S_CYCLE;
         end
         S_CYCLE: begin
            if (last) state_d = (float_slow_q || !st_q[0]) ?
               S_FLOAT : S_IDLE;
         end
         S_FLOAT: begin
            if (start) state_d = S_CYCLE;
            else if (cnt_q == 4'h0) state_d = S_IDLE;
         end
         default: state_d = S_IDLE;
      endcase
   end

   // RQ17 registered state, reset to idle
   always_ff @(posedge CLK) begin
      if (SYS_RST) state_q <= S_IDLE;
      else state_q <= state_d;
   end

   // cycle bookkeeping: latch status, selects and byte lanes
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st_q <= 3'h5;
         cmd_hi_q <= 4'h0;
         cmd_lo_q <= 4'h0;
         rom_q <= 1'b0;
         be_n_q <= 4'hf;
         cnt_q <= 4'h0;
         float_slow_q <= 1'b0;
      end else if (start) begin
         st_q <= known ? STATUS : 3'h5;
         rom_q <= ROM_SELECT;
         be_n_q <= BYTE_LANE_ENABLES_N;
         // RQ7 whole cycle length loaded at cycle start
         cnt_q <= len_sel;
         // RQ9 RQ10 RQ11 command window within the cycle
         cmd_hi_q <= hi_sel;
         cmd_lo_q <= end_sel;
         float_slow_q <= SLOW_SELECT && is_read;
      end else if (last) begin
         cnt_q <= 4'(float_slow_q ? SLOW_FLOAT : FAST_FLOAT);
      end else if (cnt_q != 4'h0) begin
         cnt_q <= 4'(cnt_q - 4'h1);
      end
   end

   // RQ13 RQ14 pipeline history
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pipe_q <= 1'b0;
      end else if (start) begin
         pipe_q <= 1'b0;
      end else if (last) begin
         pipe_q <= rom_q && !HALF_WIDTH_BUS;
      end else if (state_q == S_IDLE) begin
         pipe_q <= 1'b0;
      end
   end

   // ***********************************************
   // command strobes, active low, all registered
   // ***********************************************
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mrd_q <= 1'b0;
         iord_q <= 1'b0;
         mwr_q <= 1'b0;
         iowr_q <= 1'b0;
         irq_ack_cmd_q <= 1'b0;
      end else begin
         // RQ1 RQ2 RQ3 RQ4 RQ5 strobe per cycle type
         mrd_q <= cmd_on && ((st_q == ST_CODE) || (st_q == ST_DATA));
         iord_q <= cmd_on && (st_q == ST_IORD);
         mwr_q <= cmd_on && (st_q == ST_MWR);
         iowr_q <= cmd_on && (st_q == ST_IOWR);
         irq_ack_cmd_q <= cmd_on && (st_q == ST_IRQ_ACK_CMD);
      end
   end

   // registered pin drivers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         MEM_READ_CMD_N <= 1'b1;
         IO_READ_CMD_N <= 1'b1;
         MEM_WRITE_CMD_N <= 1'b1;
         IO_WRITE_CMD_N <= 1'b1;
         IRQ_ACK_CMD_N <= 1'b1;
         ROM_OE_N <= 1'b1;
         SRAM_OE_N <= 1'b1;
         SRAM_WE_N <= 4'hf;
         CYCLE_DONE_N <= 1'b1;
         NEXT_ADDR_REQ_N <= 1'b1;
         ADDR_LATCH <= 1'b0;
         XCVR_DIRECTION <= 1'b0;
         XCVR_ENABLE_N <= 1'b1;
      end else begin
         MEM_READ_CMD_N <= !mrd_q;
         IO_READ_CMD_N <= !iord_q;
         MEM_WRITE_CMD_N <= !mwr_q;
         IO_WRITE_CMD_N <= !iowr_q;
         IRQ_ACK_CMD_N <= !irq_ack_cmd_q;
         // RQ15 rom output enable follows read command
         ROM_OE_N <= !mrd_q;
         SRAM_OE_N <= !mrd_q;
         // RQ16 byte qualified write enables
         SRAM_WE_N <= ~({4{mwr_q}} & ~be_n_q);
         // RQ7 cycle done on the final period
         CYCLE_DONE_N <= !(state_q == S_CYCLE && cnt_q == 4'h2);
         // RQ12 RQ20 next address during rom cycles, not half width
         NEXT_ADDR_REQ_N <= !(state_q == S_CYCLE && rom_q &&
            !HALF_WIDTH_BUS);
         // RQ18 latch strobe at cycle start
         ADDR_LATCH <= start;
         // RQ19 latched direction, enable during the cycle
         XCVR_DIRECTION <= (state_q == S_CYCLE) ? st_q[0] : XCVR_DIRECTION;
         XCVR_ENABLE_N <= !(state_q == S_CYCLE);
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   one_cmd_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      $onehot0({mrd_q, iord_q, mwr_q, iowr_q, irq_ack_cmd_q}))
      else $error("two command strobes active"); // RQ6
   mrd_type_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      mrd_q |-> (st_q == ST_CODE || st_q == ST_DATA))
      else $error("read command on wrong cycle"); // RQ1
   we_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !SRAM_WE_N[0] |-> !MEM_WRITE_CMD_N && !be_n_q[0])
      else $error("write enable without lane"); // RQ16
   rom_oe_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      ROM_OE_N == MEM_READ_CMD_N)
      else $error("rom enable differs from read"); // RQ15
   na_half_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      HALF_WIDTH_BUS |=> NEXT_ADDR_REQ_N)
      else $error("next address with half width"); // RQ20
   done_bound_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      start |-> ##[3:12] !CYCLE_DONE_N)
      else $error("cycle never completed"); // RQ7
   ale_start_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      start |=> ADDR_LATCH)
      else $error("no address latch at start"); // RQ18
   io_wr_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      iowr_q |-> st_q == ST_IOWR)
      else $error("io write on wrong cycle"); // RQ4
   reset_idle_a: assert property (@(posedge CLK)
      SYS_RST |=> state_q == S_IDLE)
      else $error("reset did not idle"); // RQ17
   rd_cov: cover property (@(posedge CLK) !MEM_READ_CMD_N);
   wr_cov: cover property (@(posedge CLK) !SRAM_WE_N[3]);
   ack_cov: cover property (@(posedge CLK) !IRQ_ACK_CMD_N);
   pipe_cov: cover property (@(posedge CLK) start && pipe_q);
endmodule // lbc_ctrl

//--- lbc_ctrl_tb.sv
// self-checking bench for the local bus command controller
`timescale 1ns/1ns
module lbc_ctrl_tb
   import lbc_pkg::*;
;
   logic CLK, SYS_RST, ADS_N, FAST_SELECT, SLOW_SELECT, ROM_SELECT;
   logic HALF_WIDTH_BUS, MEM_READ_CMD_N, IO_READ_CMD_N, MEM_WRITE_CMD_N;
   logic IO_WRITE_CMD_N, IRQ_ACK_CMD_N, CYCLE_DONE_N, NEXT_ADDR_REQ_N;
   logic ADDR_LATCH, XCVR_DIRECTION, XCVR_ENABLE_N, ROM_OE_N, SRAM_OE_N;
   logic [2:0] STATUS;
   logic [3:0] BYTE_LANE_ENABLES_N, SRAM_WE_N;
   logic [15:0] obs;
   int n_fail = 0;
   int samples_checked = 0;
   int lf, ls;
   // observed outputs packed for the master model
   assign obs = {CYCLE_DONE_N, MEM_READ_CMD_N, IO_READ_CMD_N,
      MEM_WRITE_CMD_N, IO_WRITE_CMD_N, IRQ_ACK_CMD_N, NEXT_ADDR_REQ_N,
      ADDR_LATCH, XCVR_DIRECTION, XCVR_ENABLE_N, ROM_OE_N, SRAM_WE_N,
      SRAM_OE_N};
   lbc_ctrl i_lbc_ctrl (.CLK(CLK), .SYS_RST(SYS_RST), .ADS_N(ADS_N),
      .STATUS(STATUS), .FAST_SELECT(FAST_SELECT),
      .SLOW_SELECT(SLOW_SELECT), .ROM_SELECT(ROM_SELECT),
      .HALF_WIDTH_BUS(HALF_WIDTH_BUS),
      .BYTE_LANE_ENABLES_N(BYTE_LANE_ENABLES_N),
      .MEM_READ_CMD_N(MEM_READ_CMD_N), .IO_READ_CMD_N(IO_READ_CMD_N),
      .MEM_WRITE_CMD_N(MEM_WRITE_CMD_N), .IO_WRITE_CMD_N(IO_WRITE_CMD_N),
      .IRQ_ACK_CMD_N(IRQ_ACK_CMD_N), .CYCLE_DONE_N(CYCLE_DONE_N),
      .NEXT_ADDR_REQ_N(NEXT_ADDR_REQ_N), .ADDR_LATCH(ADDR_LATCH),
      .XCVR_DIRECTION(XCVR_DIRECTION), .XCVR_ENABLE_N(XCVR_ENABLE_N),
      .ROM_OE_N(ROM_OE_N), .SRAM_WE_N(SRAM_WE_N), .SRAM_OE_N(SRAM_OE_N));
   lbc_proc_model i_lbc_proc_model (.CLK(CLK), .OBS(obs), .ADS_N(ADS_N),
      .STATUS(STATUS), .FAST_SELECT(FAST_SELECT),
      .SLOW_SELECT(SLOW_SELECT), .ROM_SELECT(ROM_SELECT),
      .HALF_WIDTH_BUS(HALF_WIDTH_BUS),
      .BYTE_LANE_ENABLES_N(BYTE_LANE_ENABLES_N));
   // 50 mhz double clock
   initial CLK = 1'b0;
   always #10 CLK = ~CLK;
   // ****************************************
   // compare, cycle and verdict helpers
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic run(input logic [2:0] st, input logic fs,
      input logic rom, input logic half, input logic [3:0] be, input int gap);
      i_lbc_proc_model.bus_cycle(st, fs, rom, half, be, gap);
      check(8'(i_lbc_proc_model.len < 99), 8'h01);
      check(8'(i_lbc_proc_model.lat), 8'h01);
      check({7'h0, i_lbc_proc_model.oe_bad}, 8'h00);
      check({7'h0, i_lbc_proc_model.dir_bad}, 8'h00);
   endtask
   task automatic results();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_commands();
      logic [2:0] sts [7] = '{ST_CODE, ST_DATA, ST_IORD, ST_MWR, ST_IOWR,
         ST_IRQ_ACK_CMD, ST_IRQ_ACK_CMD};
      logic [4:0] exps [7] = '{5'h10, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01,
         5'h01};
      for (int i = 0; i < 7; i++) begin
         run(sts[i], 1'b1, 1'b0, 1'b0, 4'h0, 4);
         check({3'h0, i_lbc_proc_model.cmds}, {3'h0, exps[i]});
      end
   endtask
   task automatic t_waits();
      int lw;
      run(ST_DATA, 1'b1, 1'b0, 1'b0, 4'hf, 4);
      lf = i_lbc_proc_model.len;
      run(ST_DATA, 1'b0, 1'b0, 1'b0, 4'hf, 4);
      ls = i_lbc_proc_model.len;
      check(8'(ls - lf), 8'((SLOW_WS_UNPIPE - FAST_RD_WS_UNPIPE) * 2));
      run(ST_MWR, 1'b1, 1'b0, 1'b0, 4'h0, 4);
      lw = i_lbc_proc_model.len;
      check(8'(lw - lf), 8'((FAST_WR_WS_UNPIPE - FAST_RD_WS_UNPIPE) * 2));
      run(ST_IOWR, 1'b0, 1'b0, 1'b0, 4'h0, 4);
      check(8'(i_lbc_proc_model.len), 8'(ls));
   endtask
   task automatic t_rom();
      run(ST_CODE, 1'b0, 1'b1, 1'b0, 4'h0, 0);
      check(8'(i_lbc_proc_model.len), 8'(ls));
      check({7'h0, i_lbc_proc_model.na}, 8'h01);
      check(8'(i_lbc_proc_model.rdw), 8'(ROM_RD_WIDTH));
      run(ST_CODE, 1'b0, 1'b1, 1'b0, 4'h0, 0);
      check(8'(i_lbc_proc_model.len), 8'(ls - 2 * SLOW_WS_UNPIPE + 2));
      run(ST_DATA, 1'b1, 1'b0, 1'b0, 4'h0, 4);
      check(8'(i_lbc_proc_model.len), 8'(lf - 2));
   endtask
   task automatic t_half();
      run(ST_CODE, 1'b0, 1'b1, 1'b1, 4'h0, 0);
      check({7'h0, i_lbc_proc_model.na}, 8'h00);
      run(ST_DATA, 1'b1, 1'b0, 1'b0, 4'h0, 4);
      check(8'(i_lbc_proc_model.len), 8'(lf));
   endtask
   task automatic t_lanes();
      logic [3:0] bes [5] = '{4'h0, 4'h5, 4'ha, 4'he, 4'h7};
      for (int i = 0; i < 5; i++) begin
         run(ST_MWR, 1'b1, 1'b0, 1'b0, bes[i], 4);
         check({4'h0, i_lbc_proc_model.we_n}, {4'h0, bes[i]});
      end
      run(ST_IOWR, 1'b1, 1'b0, 1'b0, 4'h0, 4);
      check({4'h0, i_lbc_proc_model.we_n}, 8'h0f);
   endtask
   // main sequence
   initial begin
      SYS_RST = 1'b1;
      repeat (8) @(negedge CLK);
      check({2'h0, obs[15:10]}, 8'h3f);
      check({7'h0, obs[8]}, 8'h00);
      SYS_RST = 1'b0;
      t_commands();
      t_waits();
      t_rom();
      t_half();
      t_lanes();
      i_lbc_proc_model.bus_cycle(3'h5, 1'b1, 1'b0, 1'b0, 4'hf, 30);
      check({3'h0, i_lbc_proc_model.cmds}, 8'h00);
      results();
   end
   // watchdog against a hung handshake
   initial begin
      #100000;
      n_fail++;
      results();
   end
endmodule // lbc_ctrl_tb

//--- lbc_pkg.sv
// constants and types for the local bus command controller
// Notes on behaviour
// RQ1 - memory data and code reads both raise the memory read command
// RQ2 - i/o read cycles raise the i/o read command
// RQ3 - memory write cycles raise the memory write command
// RQ4 - i/o write cycles raise the i/o write command
// RQ5 - acknowledge cycles raise irq acknowledge; the second one fetches the vector
// RQ6 - status 000 ack, 010 io rd, 011 io wr, 100 code, 110 data, 111 write
// RQ7 - count wait states, then pulse cycle done to end the bus cycle
// RQ8 - decoder gives fast or slow select; controller picks matching timing
// RQ9 - fast: reads 0/1 waits, writes 1/2, command delay 1, float 2
// RQ10 - slow: 1/2 waits, command delay 2, read float 4
// RQ11 - slow rom reads hold the read command four double clock periods
// RQ12 - request next address during consecutive rom accesses
// RQ13 - first rom cycle after idle is unpipelined
// RQ14 - cycle after the last rom access counts as pipelined; the code does so only while half width bus is low
// RQ15 - memory read command drives every rom output enable
// RQ16 - sram write enables are write command gated by latched byte enables
// RQ17 - everything registered on double clock, idle after reset
// RQ18 - address latch strobe active at start of every cycle
// RQ19 - transceiver direction is latched write_not_read; enable is active low
// RQ20 - never request next address while half width bus is asserted
package lbc_pkg;
   // ***********************************************
   // cycle status codes {mem_not_io,data_not_code,write_not_read}
   // ***********************************************
   localparam logic [2:0] ST_IRQ_ACK_CMD = 3'h0;
   localparam logic [2:0] ST_IORD = 3'h2;
   localparam logic [2:0] ST_IOWR = 3'h3;
   localparam logic [2:0] ST_CODE = 3'h4;
   localparam logic [2:0] ST_DATA = 3'h6;
   localparam logic [2:0] ST_MWR = 3'h7;
   // ***********************************************
   // timing in double clock periods; wait state counts in processor clocks
   // ***********************************************
   localparam logic [3:0] FAST_RD_WS_PIPE = 4'h0;
   localparam logic [3:0] FAST_RD_WS_UNPIPE = 4'h1;
   localparam logic [3:0] FAST_WR_WS_PIPE = 4'h1;
   localparam logic [3:0] FAST_WR_WS_UNPIPE = 4'h2;
   localparam logic [3:0] SLOW_WS_PIPE = 4'h1;
   localparam logic [3:0] SLOW_WS_UNPIPE = 4'h2;
   localparam logic [3:0] FAST_CMD_DLY = 4'h1;
   localparam logic [3:0] SLOW_CMD_DLY = 4'h2;
   localparam logic [3:0] FAST_FLOAT = 4'h2;
   localparam logic [3:0] SLOW_FLOAT = 4'h4;
   localparam logic [3:0] ROM_RD_WIDTH = 4'h4;
   // double clock periods per processor clock (one wait state)
   localparam logic [3:0] DOUBLE_CLOCK_PER_T = 4'h2;
   // base cycle: two processor clocks
   localparam logic [3:0] BASE_DOUBLE_CLOCK = 4'h4;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_CYCLE = 2'b01,
      S_FLOAT = 2'b10
   } state_t;
endpackage

//--- lbc_proc_model.sv
// processor-side bus master model for the command controller
`timescale 1ns/1ns
module lbc_proc_model (
   input wire logic CLK,
   input wire logic [15:0] OBS,
   output logic ADS_N,
   output logic [2:0] STATUS,
   output logic FAST_SELECT,
   output logic SLOW_SELECT,
   output logic ROM_SELECT,
   output logic HALF_WIDTH_BUS,
   output logic [3:0] BYTE_LANE_ENABLES_N
);
   // what the last cycle showed, read by the bench
   int len, rdw, lat;
   logic [4:0] cmds;
   logic [3:0] we_n;
   logic na, oe_bad, dir_bad;
   // idle bus at time zero
   initial begin
      ADS_N = 1'b1;
      STATUS = 3'h5;
      FAST_SELECT = 1'b0;
      SLOW_SELECT = 1'b0;
      ROM_SELECT = 1'b0;
      HALF_WIDTH_BUS = 1'b0;
      BYTE_LANE_ENABLES_N = 4'hf;
   end
   // OBS: done,rd,iord,wr,iowr,ack,na,ale,dir,den,romoe,we[3:0],oe
   task automatic bus_cycle(input logic [2:0] st, input logic fs,
      input logic rom, input logic half, input logic [3:0] be, input int gap);
      int n;
      n = 0;
      len = 99;
      rdw = 0;
      lat = 0;
      cmds = 5'h00;
      we_n = 4'hf;
      na = 1'b0;
      oe_bad = 1'b0;
      dir_bad = 1'b0;
      ADS_N = 1'b0;
      STATUS = st;
      FAST_SELECT = fs;
      SLOW_SELECT = ~fs;
      ROM_SELECT = rom;
      HALF_WIDTH_BUS = half;
      BYTE_LANE_ENABLES_N = be;
      while (n < 40 && len == 99) begin
         @(negedge CLK);
         n++;
         ADS_N = 1'b1;
         cmds = cmds | ~OBS[14:10];
         we_n = we_n & OBS[4:1];
         if (OBS[14] === 1'b0) rdw++;
         if (OBS[9] === 1'b0) na = 1'b1;
         if (OBS[8] === 1'b1) lat++;
         if (OBS[5] !== OBS[14] || OBS[0] !== OBS[14]) oe_bad = 1'b1;
         if (OBS[6] === 1'b0 && OBS[7] !== st[0]) dir_bad = 1'b1;
         if (OBS[15] === 1'b0) len = n;
      end
      // let the edge that samples cycle done pass; a request there is refused
      @(negedge CLK);
      // released lines no longer show the old values
      if (gap > 0) begin
         STATUS = ~st;
         FAST_SELECT = ~fs;
         SLOW_SELECT = fs;
         ROM_SELECT = ~rom;
         HALF_WIDTH_BUS = ~half;
         BYTE_LANE_ENABLES_N = ~be;
         repeat (gap) @(negedge CLK);
      end
   endtask
endmodule // lbc_proc_model
